// ==== swfc_regs.sv ====
// Behaviour
// - Payload bytes two, one and zero are read-write 8-bit registers at 0x31, 0x32 and 0x33.
// - Bits 7:6 of the fast-data control register read as zero and ignore writes.
// - The error-counter disable bit stops the wake error counter only while tolerance enable is one.
// - Hardware clears the error-counter disable bit when the bus silence timeout expires.
// - Filter code 001 gives 100 ns and each higher code adds 50 ns up to 110 giving 350 ns.
// - The bypass bit bypasses only the analog receive filter; the digital filter stays active.
// - All thirteen trim bits accept writes only while the trim unlock field holds binary 11.
// - The five low trim bits form a monotonic 32-step fine frequency adjustment.
// - The receiver select bit picks the low-power receiver when one and is writable only when unlocked.
// - Calibration high and low are read-only 8-bit registers that reset to zero.
module swfc_regs
  import swfc_pkg::*;
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_ARST_N,
  // Register port
  input  wire swfc_wreq_t I_WREQ,
  input  wire logic [6:0] I_RD_ADDR,
  output logic      [7:0] O_RD_DATA,
  // Device side
  input  wire logic [1:0] I_TRIM_UNLOCK,
  input  wire logic       I_SILENCE_EXPIRED,
  input  wire logic [7:0] I_CAL_HIGH,
  input  wire logic [7:0] I_CAL_LOW,
  output swfc_cfg_t       O_CFG,
  output logic      [7:0] O_PAYLOAD_BYTE3,
  output logic      [7:0] O_PAYLOAD_BYTE2,
  output logic      [7:0] O_PAYLOAD_BYTE1,
  output logic      [7:0] O_PAYLOAD_BYTE0
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] fd_ctrl;
  logic [7:0] fine_trim;
  logic [7:0] options;
  logic [7:0] cal_high;
  logic [7:0] cal_low;
  logic [1:0] unlock_s1;
  logic [1:0] unlock_s2;
  logic [1:0] unlock_s3;
  logic       silence_s1;
  logic       silence_s2;
  logic [7:0] next_rd_data;
  logic       unlocked;

  function automatic logic hit(input swfc_wreq_t req, input logic [6:0] addr);
    hit = req.wr && (req.addr == addr);
  endfunction

  // Filter cycles at the core clock for a code; ceiling of the time.
  function automatic logic [5:0] filt_cycles(input logic [2:0] code);
    int ns;
    ns = FILT_BASE_NS + (int'(code) - 1) * FILT_STEP_NS;
    filt_cycles = 6'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // ****************************************************************
  // Synchronisers for outside levels
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      unlock_s1  <= 2'h0;
      unlock_s2  <= 2'h0;
      unlock_s3  <= 2'h0;
      silence_s1 <= 1'b0;
      silence_s2 <= 1'b0;
    end else begin
      unlock_s1  <= I_TRIM_UNLOCK;
      unlock_s2  <= unlock_s1;
      unlock_s3  <= unlock_s2;
      silence_s1 <= I_SILENCE_EXPIRED;
      silence_s2 <= silence_s1;
    end
  end

  // Two equal samples in a row keep a skewed pass through 11 from opening the lock.
  assign unlocked = (unlock_s2 == TRIM_UNLOCK_CODE) && (unlock_s3 == TRIM_UNLOCK_CODE);

  // ****************************************************************
  // Payload bytes
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PAYLOAD_BYTE3 <= RESET_ZERO;
      O_PAYLOAD_BYTE2 <= RESET_ZERO;
      O_PAYLOAD_BYTE1 <= RESET_ZERO;
      O_PAYLOAD_BYTE0 <= RESET_ZERO;
    end else begin
      if (hit(I_WREQ, ADDR_PAYLOAD_BYTE3)) begin
        O_PAYLOAD_BYTE3 <= I_WREQ.data;
      end
      if (hit(I_WREQ, ADDR_PAYLOAD_BYTE2)) begin
        O_PAYLOAD_BYTE2 <= I_WREQ.data;
      end
      if (hit(I_WREQ, ADDR_PAYLOAD_BYTE1)) begin
        O_PAYLOAD_BYTE1 <= I_WREQ.data;
      end
      if (hit(I_WREQ, ADDR_PAYLOAD_BYTE0)) begin
        O_PAYLOAD_BYTE0 <= I_WREQ.data;
      end
    end
  end

  // ****************************************************************
  // Fast-data control
  // ****************************************************************
  // Silence expiry has priority over a software write of the disable bit.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      fd_ctrl <= RESET_ZERO;
    end else begin
      if (hit(I_WREQ, ADDR_FD_CONTROL)) begin
        fd_ctrl <= I_WREQ.data & FD_WRITE_MASK;
      end
      if (silence_s2) begin
        fd_ctrl[FD_ERRDIS_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Trim and options
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      fine_trim <= RESET_FINE_TRIM;
      options   <= RESET_OPTIONS;
    end else begin
      if (hit(I_WREQ, ADDR_FINE_TRIM) && unlocked) begin
        fine_trim <= I_WREQ.data;
      end
      if (hit(I_WREQ, ADDR_OPTIONS) && unlocked) begin
        options <= I_WREQ.data & OPT_WRITE_MASK;
      end
    end
  end

  // ****************************************************************
  // Calibration status
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cal_high <= RESET_ZERO;
      cal_low  <= RESET_ZERO;
    end else begin
      cal_high <= I_CAL_HIGH;
      cal_low  <= I_CAL_LOW;
    end
  end

  // ****************************************************************
  // Configuration toward the frame engine
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CFG <= '0;
    end else begin
      O_CFG.fd_tolerance_enable    <= fd_ctrl[FD_EN_BIT];
      O_CFG.error_counter_stop     <= fd_ctrl[FD_ERRDIS_BIT] & fd_ctrl[FD_EN_BIT];
      O_CFG.analog_filter_bypass   <= fd_ctrl[FD_BYP_BIT];
      O_CFG.glitch_filter_code     <= fd_ctrl[FD_FILT_LSB +: 3];
      O_CFG.glitch_filter_reserved <= (fd_ctrl[FD_FILT_LSB +: 3] == 3'h0)
                                      || (fd_ctrl[FD_FILT_LSB +: 3] == 3'h7);
      O_CFG.glitch_filter_cycles   <= filt_cycles(fd_ctrl[FD_FILT_LSB +: 3]);
      O_CFG.low_power_receiver     <= options[OPT_RXSEL_BIT];
      O_CFG.trim                   <= {options[4:0], fine_trim};
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    case (I_RD_ADDR)
      ADDR_PAYLOAD_BYTE3: next_rd_data = O_PAYLOAD_BYTE3;
      ADDR_PAYLOAD_BYTE2: next_rd_data = O_PAYLOAD_BYTE2;
      ADDR_PAYLOAD_BYTE1: next_rd_data = O_PAYLOAD_BYTE1;
      ADDR_PAYLOAD_BYTE0: next_rd_data = O_PAYLOAD_BYTE0;
      ADDR_FD_CONTROL:    next_rd_data = fd_ctrl;
      ADDR_FINE_TRIM:     next_rd_data = fine_trim;
      ADDR_OPTIONS:       next_rd_data = options;
      ADDR_CAL_HIGH:      next_rd_data = cal_high;
      ADDR_CAL_LOW:       next_rd_data = cal_low;
      default:            next_rd_data = RESET_ZERO;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_DATA <= RESET_ZERO;
    end else begin
      O_RD_DATA <= next_rd_data;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence fd_write_s;
    I_WREQ.wr && I_WREQ.addr == ADDR_FD_CONTROL;
  endsequence

  payload_write_a: assert property (
    hit(I_WREQ, ADDR_PAYLOAD_BYTE2) |=> O_PAYLOAD_BYTE2 == $past(I_WREQ.data))
    else $error("payload byte two not stored");

  fd_reserved_a: assert property (fd_ctrl[7:6] == 2'h0)
    else $error("reserved bits of fast-data control set");

  errcnt_stop_a: assert property (
    ##2 O_CFG.error_counter_stop == ($past(fd_ctrl[FD_ERRDIS_BIT]) && $past(fd_ctrl[FD_EN_BIT])))
    else $error("error counter stop wrong");

  silence_clear_a: assert property (silence_s2 |=> !fd_ctrl[FD_ERRDIS_BIT])
    else $error("disable bit not cleared on silence");

  filter_time_a: assert property (
    fd_write_s ##1 (fd_ctrl[3:1] == 3'h6) [*2] |=> O_CFG.glitch_filter_cycles == 6'h23)
    else $error("filter time for 350 ns wrong");

  trim_lock_a: assert property (
    !unlocked |=> $stable(fine_trim) && $stable(options))
    else $error("trim changed while locked");

  rxsel_write_a: assert property (
    hit(I_WREQ, ADDR_OPTIONS) && unlocked |=> options[OPT_RXSEL_BIT] == $past(I_WREQ.data[OPT_RXSEL_BIT]))
    else $error("receiver select not written");

  cal_read_a: assert property (
    I_RD_ADDR == ADDR_CAL_LOW |-> ##1 O_RD_DATA == $past(cal_low))
    else $error("calibration low read wrong");

  reserved_code_a: assert property (
    fd_write_s ##1 (fd_ctrl[3:1] == 3'h7) [*2] |=> O_CFG.glitch_filter_reserved)
    else $error("reserved filter code not flagged");

  sequence fine_write_s;
    hit(I_WREQ, ADDR_FINE_TRIM) && unlocked;
  endsequence

  payload_one_a: assert property (
    hit(I_WREQ, ADDR_PAYLOAD_BYTE1) |=> O_PAYLOAD_BYTE1 == $past(I_WREQ.data))
    else $error("payload byte one not stored");

  payload_zero_a: assert property (
    hit(I_WREQ, ADDR_PAYLOAD_BYTE0) |=> O_PAYLOAD_BYTE0 == $past(I_WREQ.data))
    else $error("payload byte zero not stored");

  fd_write_a: assert property (
    hit(I_WREQ, ADDR_FD_CONTROL) && !silence_s2 |=> fd_ctrl == ($past(I_WREQ.data) & FD_WRITE_MASK))
    else $error("fast-data control write not stored");

  tolerance_map_a: assert property (
    O_CFG.fd_tolerance_enable == $past(fd_ctrl[FD_EN_BIT]))
    else $error("tolerance enable not passed on");

  errcnt_hold_a: assert property (
    !fd_ctrl[FD_EN_BIT] |=> !O_CFG.error_counter_stop)
    else $error("error counter stopped without tolerance enable");

  bypass_map_a: assert property (
    O_CFG.analog_filter_bypass == $past(fd_ctrl[FD_BYP_BIT])
    && O_CFG.glitch_filter_code == $past(fd_ctrl[FD_FILT_LSB +: 3]))
    else $error("bypass changed the digital filter");

  filter_min_a: assert property (
    fd_write_s ##1 (fd_ctrl[3:1] == 3'h1) [*2] |=> O_CFG.glitch_filter_cycles == 6'h0A)
    else $error("filter time for 100 ns wrong");

  fine_write_a: assert property (
    fine_write_s |=> fine_trim == $past(I_WREQ.data))
    else $error("unlocked trim write not stored");

  trim_map_a: assert property (
    O_CFG.trim == $past({options[4:0], fine_trim}))
    else $error("trim bits not passed on");

  rxsel_map_a: assert property (
    O_CFG.low_power_receiver == $past(options[OPT_RXSEL_BIT]))
    else $error("receiver select not passed on");

  cal_capture_a: assert property (
    cal_high == $past(I_CAL_HIGH) && cal_low == $past(I_CAL_LOW))
    else $error("calibration not captured");

  cal_high_read_a: assert property (
    I_RD_ADDR == ADDR_CAL_HIGH |-> ##1 O_RD_DATA == $past(cal_high))
    else $error("calibration high read wrong");

  reserved_zero_a: assert property (
    fd_write_s ##1 (fd_ctrl[3:1] == 3'h0) [*2] |=> O_CFG.glitch_filter_reserved)
    else $error("reserved filter code zero not flagged");

endmodule // swfc_regs

// ==== swfc_pkg.sv ====
package swfc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] ADDR_PAYLOAD_BYTE3 = 7'h30;
  localparam logic [6:0] ADDR_PAYLOAD_BYTE2 = 7'h31;
  localparam logic [6:0] ADDR_PAYLOAD_BYTE1 = 7'h32;
  localparam logic [6:0] ADDR_PAYLOAD_BYTE0 = 7'h33;
  localparam logic [6:0] ADDR_FD_CONTROL    = 7'h34;
  localparam logic [6:0] ADDR_FINE_TRIM     = 7'h38;
  localparam logic [6:0] ADDR_OPTIONS       = 7'h39;
  localparam logic [6:0] ADDR_CAL_HIGH      = 7'h3A;
  localparam logic [6:0] ADDR_CAL_LOW       = 7'h3B;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int         FD_EN_BIT        = 0;
  localparam int         FD_FILT_LSB      = 1;
  localparam int         FD_BYP_BIT       = 4;
  localparam int         FD_ERRDIS_BIT    = 5;
  localparam logic [7:0] FD_WRITE_MASK    = 8'h3F;
  localparam logic [7:0] OPT_WRITE_MASK   = 8'h9F;
  localparam int         OPT_RXSEL_BIT    = 7;
  localparam logic [1:0] TRIM_UNLOCK_CODE = 2'h3;
  localparam logic [7:0] RESET_ZERO       = 8'h00;
  localparam logic [7:0] RESET_FINE_TRIM  = 8'h00;
  localparam logic [7:0] RESET_OPTIONS    = 8'h00;

  // ****************************************************************
  // Filter timing
  // ****************************************************************
  localparam int FILT_BASE_NS = 100;
  localparam int FILT_STEP_NS = 50;
  localparam int CLK_PERIOD_NS = 10;

  // Register write request from the serial port.
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } swfc_wreq_t;

  // Decoded configuration toward the frame engine.
  typedef struct packed {
    logic       fd_tolerance_enable;
    logic       error_counter_stop;
    logic       analog_filter_bypass;
    logic [2:0] glitch_filter_code;
    logic       glitch_filter_reserved;
    logic [5:0] glitch_filter_cycles;
    logic       low_power_receiver;
    logic [12:0] trim;
  } swfc_cfg_t;

endpackage : swfc_pkg

// ==== swfc_osc_model.sv ====
// ****************************************************************
// Oscillator and bus silence source seen by the register bank
// ****************************************************************
module swfc_osc_model #(
  parameter logic [7:0] CAL_HIGH_VAL = 8'hA5,
  parameter logic [7:0] CAL_LOW_VAL  = 8'h3C
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Commands from the bench
  input  wire logic       i_cal_load,
  input  wire logic       i_silence_req,
  // Device side
  output logic      [7:0] o_cal_high,
  output logic      [7:0] o_cal_low,
  output logic            o_silence
);
  timeunit 1ns;
  timeprecision 1ps;

  // Calibration stays zero until the bench asks for a finished calibration.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cal_high <= 8'h00;
      o_cal_low  <= 8'h00;
      o_silence  <= 1'b0;
    end else begin
      o_cal_high <= i_cal_load ? CAL_HIGH_VAL : 8'h00;
      o_cal_low  <= i_cal_load ? CAL_LOW_VAL : 8'h00;
      o_silence  <= i_silence_req;
    end
  end
endmodule // swfc_osc_model

// ==== test_selective_wake_frame_config.sv ====
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
// ****************************************************************
// Register bank bench
// ****************************************************************
module test_selective_wake_frame_config;
  timeunit 1ns;
  timeprecision 1ps;
  import swfc_pkg::*;
  logic       i_clk, i_arst_n, cal_load, silence_req, silence;
  swfc_wreq_t wreq;
  swfc_cfg_t  cfg;
  logic [6:0] rd_addr;
  logic [1:0] unlock;
  logic [7:0] rd_data, cal_h, cal_l, pay3, pay2, pay1, pay0;
  int         err_count, check_count, cycles;

  swfc_osc_model u_osc (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cal_load(cal_load),
    .i_silence_req(silence_req), .o_cal_high(cal_h), .o_cal_low(cal_l), .o_silence(silence));
  swfc_regs u_dut (.I_CLK(i_clk), .I_ARST_N(i_arst_n), .I_WREQ(wreq), .I_RD_ADDR(rd_addr),
    .O_RD_DATA(rd_data), .I_TRIM_UNLOCK(unlock), .I_SILENCE_EXPIRED(silence), .I_CAL_HIGH(cal_h),
    .I_CAL_LOW(cal_l), .O_CFG(cfg), .O_PAYLOAD_BYTE3(pay3), .O_PAYLOAD_BYTE2(pay2),
    .O_PAYLOAD_BYTE1(pay1), .O_PAYLOAD_BYTE0(pay0));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk) wreq = '{1'b1, a, d};
    @(negedge i_clk) wreq.wr = 1'b0;
  endtask

  // The decoded configuration lands one edge after the register.
  task automatic wcfg(input logic [6:0] a, input logic [7:0] d);
    wr(a, d);
    @(negedge i_clk);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
    @(negedge i_clk) rd_addr = a;
    @(negedge i_clk) `CHK(nm, e, rd_data)
  endtask

  task automatic settle();
    repeat (3) @(negedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    i_arst_n = 1'b0;
    wreq = '0;
    rd_addr = 7'h00;
    unlock = 2'h0;
    cal_load = 1'b0;
    silence_req = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk) i_arst_n = 1'b1;
    for (int a = 8'h30; a <= 8'h3C; a++) rd(7'(a), 8'h00, "reset value");
    for (int i = 0; i < 4; i++) wr(7'(ADDR_PAYLOAD_BYTE3 + i), 8'(8'hC0 + i));
    for (int i = 0; i < 4; i++) rd(7'(ADDR_PAYLOAD_BYTE3 + i), 8'(8'hC0 + i), "payload");
    `CHK("payload two port", 8'hC1, pay2)
    `CHK("payload zero port", 8'hC3, pay0)
    `CHK("payload one port", 8'hC2, pay1)
    `CHK("payload three port", 8'hC0, pay3)
    wcfg(ADDR_FD_CONTROL, 8'hFF);
    `CHK("counter stop", 1'b1, cfg.error_counter_stop)
    `CHK("tolerance enable", 1'b1, cfg.fd_tolerance_enable)
    rd(ADDR_FD_CONTROL, 8'h3F, "fd control");
    wcfg(ADDR_FD_CONTROL, 8'h3E);
    `CHK("counter stop", 1'b0, cfg.error_counter_stop)
    wcfg(ADDR_FD_CONTROL, 8'h21);
    `CHK("counter stop", 1'b1, cfg.error_counter_stop)
    `CHK("analog bypass", 1'b0, cfg.analog_filter_bypass)
    @(negedge i_clk) silence_req = 1'b1;
    @(negedge i_clk) silence_req = 1'b0;
    settle();
    settle();
    rd(ADDR_FD_CONTROL, 8'h01, "silence clear");
    `CHK("counter stop", 1'b0, cfg.error_counter_stop)
    for (int c = 0; c < 8; c++) begin
      int ns;
      ns = FILT_BASE_NS + FILT_STEP_NS * (c - 1);
      wcfg(ADDR_FD_CONTROL, 8'(8'h10 | (c << FD_FILT_LSB)));
      rd(ADDR_FD_CONTROL, 8'(8'h10 | (c << FD_FILT_LSB)), "filter code");
      `CHK("filter reserved", (c == 0 || c == 7), cfg.glitch_filter_reserved)
      `CHK("analog bypass", 1'b1, cfg.analog_filter_bypass)
      `CHK("digital filter code", 3'(c), cfg.glitch_filter_code)
      `CHK("tolerance enable", 1'b0, cfg.fd_tolerance_enable)
      if (c > 0 && c < 7)
        `CHK("filter cycles", 6'(ns / CLK_PERIOD_NS), cfg.glitch_filter_cycles)
    end
    wcfg(ADDR_FINE_TRIM, 8'h1F);
    rd(ADDR_FINE_TRIM, 8'h00, "locked trim");
    @(negedge i_clk) unlock = TRIM_UNLOCK_CODE;
    settle();
    wcfg(ADDR_FINE_TRIM, 8'h1F);
    wcfg(ADDR_OPTIONS, 8'hE0);
    `CHK("low power receiver", 1'b1, cfg.low_power_receiver)
    `CHK("trim", 13'h001F, cfg.trim)
    rd(ADDR_FINE_TRIM, 8'h1F, "fine trim");
    rd(ADDR_OPTIONS, 8'h80, "options");
    @(negedge i_clk) unlock = 2'h0;
    settle();
    wr(ADDR_FINE_TRIM, 8'h00);
    wr(ADDR_OPTIONS, 8'h00);
    rd(ADDR_FINE_TRIM, 8'h1F, "relocked trim");
    rd(ADDR_OPTIONS, 8'h80, "relocked options");
    @(negedge i_clk) cal_load = 1'b1;
    settle();
    wr(ADDR_CAL_HIGH, 8'h00);
    rd(ADDR_CAL_HIGH, 8'hA5, "calibration high");
    rd(ADDR_CAL_LOW, 8'h3C, "calibration low");
    @(negedge i_clk) i_arst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_arst_n = 1'b1;
    rd(ADDR_PAYLOAD_BYTE2, 8'h00, "payload after reset");
    rd(ADDR_FD_CONTROL, 8'h00, "fd control after reset");
    rd(ADDR_FINE_TRIM, 8'h00, "trim after reset");
    `CHK("payload two port after reset", 8'h00, pay2)
    end_sim();
  end
endmodule // test_selective_wake_frame_config
